// ### pkg/nbd_pkg.sv
/*
  Constants shared by the nibble bus device: command codes, field widths,
  FIFO depth, match width and the identification code.
  Assumes a single system clock of 20 MHz and a host-made strobe.
*/
// Notes on behaviour
// RQ1 - four data lines plus active-low strobe and command/data line from the host
// RQ2 - bus driven only while strobe low; host values taken at strobe rise
// RQ3 - strobe is sampled and edge-detected, never used as a clock
// RQ4 - host starts each operation by lowering command/data before the strobe
// RQ5 - command code taken from the bus at rise of a command strobe
// RQ6 - latched command governs all data strobes until the next command strobe
// RQ7 - code 0 makes the device ignore every data strobe
// RQ8 - code 1: unconfigured device with chain high sends 5 ID nibbles
// RQ9 - codes 2/3: matched device drives data; all devices step the pointer
// RQ10 - codes 4/5: matched device stores nibbles; all devices step the pointer
// RQ11 - codes 6/7: five nibbles, low first, load fetch or data pointer
// RQ12 - after the fifth pointer nibble bit 2 of the command is cleared
// RQ13 - code 8: unconfigured device with chain high loads five config nibbles
// RQ14 - code 9: device matched by data pointer becomes unconfigured
// RQ15 - host loads data pointers right before the unconfigure command
// RQ16 - code A: device needing service drives one data line high
// RQ17 - code C: device matched by data pointer pulses its own operation
// RQ18 - code E: halt seen; the device raises a halt pulse
// RQ19 - code F: configuration flag cleared and local reset pulsed
// RQ20 - first data strobe after read command or auto-switch is a dummy
// RQ21 - device has a chain input and a chain output
// RQ22 - host precharges the bus low, so silence reads as zero
// RQ23 - chain output low when unconfigured, copies chain input when configured
// RQ24 - reads and writes answered only when pointer matches configured space
// RQ25 - command latch resets to the no-operation code
package nbd_pkg;
  localparam int NIB_W = 4;
  localparam int PTR_W = 20;
  localparam int PTR_NIBS = 5;
  localparam logic [2:0] LAST_NIB = 3'h4;
  localparam int CMD_LOAD_BIT = 2;
  localparam int POLL_LINE = 0;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_ID = 4'h1;
  localparam logic [3:0] CMD_FETCH_READ = 4'h2;
  localparam logic [3:0] CMD_DATA_READ = 4'h3;
  localparam logic [3:0] CMD_FETCH_WRITE = 4'h4;
  localparam logic [3:0] CMD_DATA_WRITE = 4'h5;
  localparam logic [3:0] CMD_FETCH_LOAD = 4'h6;
  localparam logic [3:0] CMD_DATA_LOAD = 4'h7;
  localparam logic [3:0] CMD_CONFIGURE = 4'h8;
  localparam logic [3:0] CMD_UNCONFIGURE = 4'h9;
  localparam logic [3:0] CMD_POLL = 4'ha;
  localparam logic [3:0] CMD_DEV_OP = 4'hc;
  localparam logic [3:0] CMD_HALT = 4'he;
  localparam logic [3:0] CMD_RESET = 4'hf;
  // identification code: value is arbitrary
  localparam logic [19:0] ID_CODE_DEF = 20'h5a3c7;
  localparam int WR_W = PTR_W + NIB_W;
  localparam int FIFO_DEPTH = 16;
  localparam int MATCH_DEF = 9;
  localparam logic [2:0] NIB_ZERO = 3'h0;
  localparam logic [19:0] PTR_ZERO = 20'h00000;
endpackage

// ### design/nbd_fifo.sv
/*
  Small synchronous FIFO with registered output word.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module nbd_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("nbd_fifo depth must be a power of two");
    end
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]   count_q, count_d;
  logic          outValid_q, outValid_d;
  logic [W-1:0]  outData_q, outData_d;
  logic          push, pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = outValid_q;
  assign outData  = outData_q;

  // pointer and output stage next values
  always_comb begin
    push       = inValid && inReady;
    pop        = (count_q != '0) && (!outValid_q || outReady);
    wrPtr_d    = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d    = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d    = count_q + (AW+1)'(push) - (AW+1)'(pop);
    outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
    outData_d  = pop ? mem[rdPtr_q] : outData_q;
  end

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      count_q    <= '0;
      outValid_q <= 1'b0;
      outData_q  <= '0;
    end else begin
      wrPtr_q    <= wrPtr_d;
      rdPtr_q    <= rdPtr_d;
      count_q    <= count_d;
      outValid_q <= outValid_d;
      outData_q  <= outData_d;
    end
  end
endmodule

// ### design/nbd_device.sv
/*
  Nibble bus device: command latch, pointers, configuration and chain,
  reads from a user data port, writes out through a FIFO.
  Assumes the host strobe is slow (about 400 ns) against clk_sys, and
  that user read data for rdAddr is valid one cycle after rdAddr moves.
*/
`timescale 1ns/100ps
module nbd_device
  import nbd_pkg::*;
#(
  parameter int          MATCH_BITS = MATCH_DEF,
  parameter logic [19:0] ID_CODE    = ID_CODE_DEF
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              bus_strobe_n,
  input  wire logic              cmd_data_sel_n,
  input  wire logic [NIB_W-1:0]  busIn,
  output logic [NIB_W-1:0]       busOut,
  output logic                   busOe,
  input  wire logic              chain_in,
  output logic                   chain_out,
  input  wire logic              svcReq,
  output logic [PTR_W-1:0]       rdAddr,
  input  wire logic [NIB_W-1:0]  rdData,
  output logic                   wrValid,
  input  wire logic              wrReady,
  output logic [PTR_W-1:0]       wrAddr,
  output logic [NIB_W-1:0]       wrNibble,
  output logic                   wrOverflow,
  output logic                   devOpPulse,
  output logic                   haltPulse,
  output logic                   resetPulse,
  output logic                   configured
);
  initial begin
    if (MATCH_BITS < 1 || MATCH_BITS > PTR_W) begin
      $error("nbd_device MATCH_BITS out of range");
    end
  end

  // address match on the upper bits of the configuration
  function automatic logic addrMatch(input logic [PTR_W-1:0] ptr,
                                     input logic [PTR_W-1:0] cfg,
                                     input logic             conf);
    addrMatch = conf &&
      (ptr[PTR_W-1 -: MATCH_BITS] == cfg[PTR_W-1 -: MATCH_BITS]); // [RQ24]
  endfunction

  // insert nibble n of a pointer, low nibble first
  function automatic logic [PTR_W-1:0] putNib(input logic [PTR_W-1:0] v,
                                              input logic [2:0] n,
                                              input logic [NIB_W-1:0] d);
    logic [PTR_W-1:0] r;
    r = v;
    r[n*NIB_W +: NIB_W] = d;
    putNib = r;
  endfunction

  // pin synchronisers, strobe edge found in clk_sys [RQ3]
  logic [1:0] strbSync_q, cdSync_q, chainSync_q;
  logic [NIB_W-1:0] busSync1_q, busSync2_q, busPrev_q;
  logic strbPrev_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strbSync_q  <= 2'h3;
      cdSync_q    <= 2'h3;
      chainSync_q <= 2'h0;
      busSync1_q  <= 4'h0;
      busSync2_q  <= 4'h0;
      busPrev_q   <= 4'h0;
      strbPrev_q  <= 1'b1;
    end else begin
      strbSync_q  <= {strbSync_q[0], bus_strobe_n};
      cdSync_q    <= {cdSync_q[0], cmd_data_sel_n};
      chainSync_q <= {chainSync_q[0], chain_in};
      busSync1_q  <= busIn;
      busSync2_q  <= busSync1_q;
      busPrev_q   <= busSync2_q; // bus just before the strobe rose [RQ2]
      strbPrev_q  <= strbSync_q[1];
    end
  end

  logic strb, cdLow, chainHi, strbFall, strbRise;
  assign strb     = strbSync_q[1];
  assign cdLow    = !cdSync_q[1];
  assign chainHi  = chainSync_q[1];
  assign strbFall = strbPrev_q && !strb;
  assign strbRise = !strbPrev_q && strb;

  // protocol state
  logic [3:0]       cmd_q, cmd_d;
  logic [PTR_W-1:0] fetchPtr_q, fetchPtr_d, dataPtr_q, dataPtr_d;
  logic [PTR_W-1:0] cfgReg_q, cfgReg_d;
  logic [2:0]       nibCnt_q, nibCnt_d;
  logic             dummy_q, dummy_d;
  logic             conf_q, conf_d, cfgPend_q, cfgPend_d;
  logic             pollDone_q, pollDone_d;
  logic [NIB_W-1:0] busOut_q, busOut_d;
  logic             busOe_q, busOe_d, chainOut_q, chainOut_d;
  logic [PTR_W-1:0] rdAddr_q, rdAddr_d;
  logic             pend_q, pend_d;
  logic [WR_W-1:0]  pendData_q, pendData_d;
  logic             ovf_q, ovf_d, devOp_q, devOp_d;
  logic             halt_q, halt_d, rst_q, rst_d;
  logic             fifoReady;

  logic             isRead, isWrite, useData;
  logic [PTR_W-1:0] selPtr;

  always_comb begin
    isRead  = (cmd_q == CMD_FETCH_READ) || (cmd_q == CMD_DATA_READ);
    isWrite = (cmd_q == CMD_FETCH_WRITE) || (cmd_q == CMD_DATA_WRITE);
    useData = cmd_q[0];
    selPtr  = useData ? dataPtr_q : fetchPtr_q;
  end

  // next values for the whole bus engine
  always_comb begin
    cmd_d      = cmd_q;
    fetchPtr_d = fetchPtr_q;
    dataPtr_d  = dataPtr_q;
    cfgReg_d   = cfgReg_q;
    nibCnt_d   = nibCnt_q;
    dummy_d    = dummy_q;
    conf_d     = conf_q;
    cfgPend_d  = cfgPend_q;
    pollDone_d = pollDone_q;
    busOut_d   = busOut_q;
    busOe_d    = busOe_q;
    rdAddr_d   = selPtr;
    pend_d     = pend_q && !fifoReady;
    pendData_d = pendData_q;
    ovf_d      = 1'b0;
    devOp_d    = 1'b0;
    halt_d     = 1'b0;
    rst_d      = 1'b0;
    chainOut_d = conf_q ? chainHi : 1'b0; // [RQ23] [RQ21]

    // drive only while strobe is low [RQ2] [RQ1]
    if (strbRise) begin
      busOe_d  = 1'b0;
      busOut_d = 4'h0;
    end else if (strbFall && !cdLow) begin
      unique case (cmd_q)
        CMD_ID: begin
          if (!conf_q && chainHi && nibCnt_q <= LAST_NIB) begin // [RQ8]
            busOe_d  = 1'b1;
            busOut_d = ID_CODE[nibCnt_q*NIB_W +: NIB_W];
          end
        end
        CMD_FETCH_READ, CMD_DATA_READ: begin
          if (!dummy_q && addrMatch(selPtr, cfgReg_q, conf_q)) begin // [RQ9]
            busOe_d  = 1'b1;
            busOut_d = rdData;
          end
        end
        CMD_POLL: begin
          if (!pollDone_q && svcReq) begin // [RQ16]
            busOe_d  = 1'b1;
            busOut_d = 4'h0;
            busOut_d[POLL_LINE] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (strbRise && cdLow) begin
      // command strobe: latch the code [RQ5] [RQ6] [RQ4]
      cmd_d      = busPrev_q;
      nibCnt_d   = NIB_ZERO;
      pollDone_d = 1'b0;
      dummy_d    = (busPrev_q == CMD_FETCH_READ) ||
                   (busPrev_q == CMD_DATA_READ); // [RQ20]
      if (cfgPend_q) begin
        conf_d    = 1'b1; // flag set late so the chain settles first
        cfgPend_d = 1'b0;
      end
      unique case (busPrev_q)
        CMD_UNCONFIGURE: begin
          // relies on the host having just loaded the data pointer [RQ15]
          if (addrMatch(dataPtr_q, cfgReg_q, conf_q)) begin
            conf_d = 1'b0; // [RQ14]
          end
        end
        CMD_DEV_OP: devOp_d = addrMatch(dataPtr_q, cfgReg_q, conf_q); // [RQ17]
        CMD_HALT:   halt_d = 1'b1; // [RQ18]
        CMD_RESET: begin
          conf_d    = 1'b0; // [RQ19]
          cfgPend_d = 1'b0;
          rst_d     = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (strbRise) begin
      // data strobe under the latched command [RQ6]
      unique case (cmd_q)
        CMD_NOP: begin
        end // [RQ7]
        CMD_ID: begin
          if (nibCnt_q <= LAST_NIB) begin
            nibCnt_d = nibCnt_q + 3'h1;
          end
        end
        CMD_FETCH_READ, CMD_DATA_READ: begin
          if (dummy_q) begin
            dummy_d = 1'b0; // [RQ20]
          end else if (useData) begin
            dataPtr_d = dataPtr_q + 20'h00001; // [RQ9]
          end else begin
            fetchPtr_d = fetchPtr_q + 20'h00001;
          end
        end
        CMD_FETCH_WRITE, CMD_DATA_WRITE: begin
          if (addrMatch(selPtr, cfgReg_q, conf_q)) begin // [RQ10]
            if (pend_q && !fifoReady) begin
              ovf_d = 1'b1;
            end else begin
              pend_d     = 1'b1;
              pendData_d = {selPtr, busPrev_q};
            end
          end
          if (useData) begin
            dataPtr_d = dataPtr_q + 20'h00001;
          end else begin
            fetchPtr_d = fetchPtr_q + 20'h00001;
          end
        end
        CMD_FETCH_LOAD, CMD_DATA_LOAD: begin
          if (useData) begin // [RQ11]
            dataPtr_d = putNib(dataPtr_q, nibCnt_q, busPrev_q);
          end else begin
            fetchPtr_d = putNib(fetchPtr_q, nibCnt_q, busPrev_q);
          end
          nibCnt_d = nibCnt_q + 3'h1;
          if (nibCnt_q == LAST_NIB) begin
            cmd_d[CMD_LOAD_BIT] = 1'b0; // [RQ12]
            dummy_d  = 1'b1; // [RQ20]
            nibCnt_d = NIB_ZERO;
          end
        end
        CMD_CONFIGURE: begin
          if (!conf_q && chainHi && nibCnt_q <= LAST_NIB) begin // [RQ13]
            cfgReg_d = putNib(cfgReg_q, nibCnt_q, busPrev_q);
            nibCnt_d = nibCnt_q + 3'h1;
            if (nibCnt_q == LAST_NIB) begin
              cfgPend_d = 1'b1;
            end
          end
        end
        CMD_POLL: pollDone_d = 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q      <= CMD_NOP; // [RQ25]
      fetchPtr_q <= PTR_ZERO;
      dataPtr_q  <= PTR_ZERO;
      cfgReg_q   <= PTR_ZERO;
      nibCnt_q   <= NIB_ZERO;
      dummy_q    <= 1'b0;
      conf_q     <= 1'b0;
      cfgPend_q  <= 1'b0;
      pollDone_q <= 1'b0;
      busOut_q   <= 4'h0;
      busOe_q    <= 1'b0;
      chainOut_q <= 1'b0;
      rdAddr_q   <= PTR_ZERO;
      pend_q     <= 1'b0;
      pendData_q <= '0;
      ovf_q      <= 1'b0;
      devOp_q    <= 1'b0;
      halt_q     <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      cmd_q      <= cmd_d;
      fetchPtr_q <= fetchPtr_d;
      dataPtr_q  <= dataPtr_d;
      cfgReg_q   <= cfgReg_d;
      nibCnt_q   <= nibCnt_d;
      dummy_q    <= dummy_d;
      conf_q     <= conf_d;
      cfgPend_q  <= cfgPend_d;
      pollDone_q <= pollDone_d;
      busOut_q   <= busOut_d;
      busOe_q    <= busOe_d;
      chainOut_q <= chainOut_d;
      rdAddr_q   <= rdAddr_d;
      pend_q     <= pend_d;
      pendData_q <= pendData_d;
      ovf_q      <= ovf_d;
      devOp_q    <= devOp_d;
      halt_q     <= halt_d;
      rst_q      <= rst_d;
    end
  end

  // write words queue toward the user side
  logic [WR_W-1:0] fifoOut;
  nbd_fifo #(
    .W     (WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  (pend_q),
    .inReady  (fifoReady),
    .inData   (pendData_q),
    .outValid (wrValid),
    .outReady (wrReady),
    .outData  (fifoOut)
  );

  assign wrAddr     = fifoOut[WR_W-1:NIB_W];
  assign wrNibble   = fifoOut[NIB_W-1:0];
  assign busOut     = busOut_q;
  assign busOe      = busOe_q;
  assign chain_out  = chainOut_q;
  assign rdAddr     = rdAddr_q;
  assign wrOverflow = ovf_q;
  assign devOpPulse = devOp_q;
  assign haltPulse  = halt_q;
  assign resetPulse = rst_q;
  assign configured = conf_q;
endmodule

// ### verif/nbd_device_checker.sv
/*
  Concurrent checks on the nibble bus device ports.
  Assumes the single clk_sys domain and reset_n as async reset.
*/
`timescale 1ns/100ps
module nbd_device_checker
  import nbd_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             reset_n,
  input wire logic             bus_strobe_n,
  input wire logic             cmd_data_sel_n,
  input wire logic [NIB_W-1:0] busOut,
  input wire logic             busOe,
  input wire logic             chain_in,
  input wire logic             chain_out,
  input wire logic             wrValid,
  input wire logic             wrReady,
  input wire logic [PTR_W-1:0] wrAddr,
  input wire logic [NIB_W-1:0] wrNibble,
  input wire logic             devOpPulse,
  input wire logic             haltPulse,
  input wire logic             resetPulse,
  input wire logic             configured
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // bus drive only inside strobe-low periods of data strobes
  oe_idle_a: assert property (
    !busOe |-> busOut == 4'h0) else $error("bus value while not driving");
  oe_rise_a: assert property (
    $rose(busOe) |-> !$past(bus_strobe_n, 2) && $past(cmd_data_sel_n, 2))
    else $error("drive began outside a data strobe");
  oe_fall_a: assert property (
    $fell(busOe) |-> $past(bus_strobe_n, 2))
    else $error("drive dropped while strobe low");
  // chain output follows configuration state
  chain_low_a: assert property (
    !configured && !$past(configured) |-> !chain_out)
    else $error("chain out high while unconfigured");
  chain_copy_a: assert property (
    (configured && chain_in) [*5] |-> chain_out)
    else $error("chain out not following chain in");
  // write words stand until taken
  wr_hold_a: assert property (
    wrValid && !wrReady |=> wrValid && $stable(wrAddr) && $stable(wrNibble))
    else $error("write word changed while stalled");
  // command side effects
  halt_pulse_a: assert property (
    haltPulse |=> !haltPulse) else $error("halt pulse too long");
  reset_cfg_a: assert property (
    resetPulse |-> ##[0:2] !configured)
    else $error("reset command kept configuration");
  devop_cfg_a: assert property (
    devOpPulse |-> configured ##1 !devOpPulse)
    else $error("device operation pulse wrong");
endmodule
bind nbd_device nbd_device_checker nbd_device_checker_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .bus_strobe_n(bus_strobe_n),
  .cmd_data_sel_n(cmd_data_sel_n), .busOut(busOut), .busOe(busOe),
  .chain_in(chain_in), .chain_out(chain_out), .wrValid(wrValid),
  .wrReady(wrReady), .wrAddr(wrAddr), .wrNibble(wrNibble),
  .devOpPulse(devOpPulse), .haltPulse(haltPulse),
  .resetPulse(resetPulse), .configured(configured));

// ### verif/nbd_host_model.sv
/*
  Behavioural host: makes strobes of 400 ns period and resolves the bus.
  Assumes clk_sys at 50 ns; strobe stays high between transfers.
*/
`timescale 1ns/100ps
module nbd_host_model
  import nbd_pkg::*;
(
  input  wire logic             clk_sys,
  output logic                  bus_strobe_n,
  output logic                  cmd_data_sel_n,
  output logic [NIB_W-1:0]      busWire,
  input  wire logic [NIB_W-1:0] busOut,
  input  wire logic             busOe
);
  logic             hostOe;
  logic [NIB_W-1:0] hostBus;

  // device, else host, else precharged low
  assign busWire = busOe ? busOut : (hostOe ? hostBus : 4'h0);

  initial begin
    bus_strobe_n = 1'b1;
    cmd_data_sel_n = 1'b1;
    hostOe = 1'b0;
    hostBus = 4'h0;
  end

  // one strobe: select line set first, five cycles low
  task automatic xfer(input logic cd, input logic [NIB_W-1:0] d,
                      input logic drv, output logic [NIB_W-1:0] rd);
    repeat (2) @(posedge clk_sys);
    #1 cmd_data_sel_n = cd;
    @(posedge clk_sys);
    #1 bus_strobe_n = 1'b0;
    hostOe = drv;
    hostBus = d;
    repeat (5) @(posedge clk_sys);
    rd = busWire;
    #1 bus_strobe_n = 1'b1;
    hostOe = 1'b0;
  endtask
endmodule

// ### verif/testbench.sv
/*
  Self-checking bench for the nibble bus device.
  Assumes the host model for strobes and the bound port checker.
*/
`timescale 1ns/100ps
module testbench
  import nbd_pkg::*;
  ;
  localparam logic [19:0] BASE = 20'h3a800;
  logic             clk_sys;
  logic             reset_n;
  logic             chain_in;
  logic             svcReq;
  logic             wrReady;
  logic             bus_strobe_n;
  logic             cmd_data_sel_n;
  logic             busOe;
  logic             chain_out;
  logic             wrValid;
  logic             wrOverflow;
  logic             devOpPulse;
  logic             haltPulse;
  logic             resetPulse;
  logic             configured;
  logic [NIB_W-1:0] busWire;
  logic [NIB_W-1:0] busOut;
  logic [NIB_W-1:0] rdData;
  logic [NIB_W-1:0] wrNibble;
  logic [PTR_W-1:0] rdAddr;
  logic [PTR_W-1:0] wrAddr;
  bit               seenOp;
  bit               seenHalt;
  bit               seenRst;
  bit               seenOvf;
  int               mismatches;
  int               cmp_count;

  // clock source
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  nbd_device nbd_device_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_strobe_n(bus_strobe_n),
    .cmd_data_sel_n(cmd_data_sel_n), .busIn(busWire), .busOut(busOut),
    .busOe(busOe), .chain_in(chain_in), .chain_out(chain_out),
    .svcReq(svcReq), .rdAddr(rdAddr), .rdData(rdData), .wrValid(wrValid),
    .wrReady(wrReady), .wrAddr(wrAddr), .wrNibble(wrNibble),
    .wrOverflow(wrOverflow), .devOpPulse(devOpPulse),
    .haltPulse(haltPulse), .resetPulse(resetPulse),
    .configured(configured));
  nbd_host_model nbd_host_model_inst (
    .clk_sys(clk_sys), .bus_strobe_n(bus_strobe_n),
    .cmd_data_sel_n(cmd_data_sel_n), .busWire(busWire), .busOut(busOut),
    .busOe(busOe));

  // memory content derived from address
  assign rdData = rdAddr[3:0] ^ 4'h5;

  // sticky capture of one-cycle pulses
  always @(posedge clk_sys) begin
    if (devOpPulse === 1'b1) seenOp <= 1'b1;
    if (haltPulse === 1'b1) seenHalt <= 1'b1;
    if (resetPulse === 1'b1) seenRst <= 1'b1;
    if (wrOverflow === 1'b1) seenOvf <= 1'b1;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bus helpers
  task automatic cmd(input logic [3:0] c);
    logic [3:0] r;
    nbd_host_model_inst.xfer(1'b0, c, 1'b1, r);
  endtask
  task automatic wr(input logic [3:0] d);
    logic [3:0] r;
    nbd_host_model_inst.xfer(1'b1, d, 1'b1, r);
  endtask
  task automatic rd(input logic [3:0] exp);
    logic [3:0] r;
    nbd_host_model_inst.xfer(1'b1, 4'h0, 1'b0, r);
    check(24'(r), 24'(exp));
  endtask
  task automatic load(input logic [3:0] c, input logic [19:0] p);
    cmd(c);
    for (int i = 0; i < 5; i++) wr(p[4*i +: 4]);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_idle;
    wr(4'h9);
    rd(4'h0);
    cmd(CMD_NOP);
    rd(4'h0);
    check(24'(wrValid), 24'h0);
  endtask

  task automatic t_ident;
    cmd(CMD_ID);
    for (int i = 0; i < 5; i++) rd(ID_CODE_DEF[4*i +: 4]);
    rd(4'h0);
    chain_in = 1'b0;
    cmd(CMD_ID);
    rd(4'h0);
    chain_in = 1'b1;
  endtask

  task automatic t_config;
    load(CMD_CONFIGURE, BASE);
    settle;
    check(24'(configured), 24'h0);
    cmd(CMD_NOP);
    settle;
    check(24'(configured), 24'h1);
    check(24'(chain_out), 24'h1);
    chain_in = 1'b0;
    settle;
    check(24'(chain_out), 24'h0);
    chain_in = 1'b1;
    cmd(CMD_ID);
    rd(4'h0);
  endtask

  // stall the sink, overfill, then drain in order
  task automatic t_fill_drain;
    wrReady = 1'b0;
    load(CMD_DATA_LOAD, BASE + 20'h10);
    cmd(CMD_DATA_WRITE);
    for (int i = 0; i < 19; i++) wr(4'(i));
    settle;
    check(24'(seenOvf), 24'h1);
    wrReady = 1'b1;
    for (int i = 0; i < 18; i++) begin
      for (int n = 0; n < 20 && wrValid !== 1'b1; n++) begin
        @(posedge clk_sys);
        #1;
      end
      check({wrAddr, wrNibble}, {BASE + 20'(16 + i), 4'(i)});
      @(posedge clk_sys);
      #1;
    end
    settle;
    check(24'(wrValid), 24'h0);
    // one write through the fetch pointer
    load(CMD_FETCH_LOAD, BASE + 20'h30);
    cmd(CMD_FETCH_WRITE);
    wr(4'ha);
    for (int n = 0; n < 20 && wrValid !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    check({wrAddr, wrNibble}, {BASE + 20'h30, 4'ha});
    @(posedge clk_sys);
    #1;
  endtask

  task automatic t_read;
    logic [19:0] p;
    for (int k = 0; k < 2; k++) begin
      p = BASE + 20'h20 + 20'(k);
      load(CMD_FETCH_LOAD + 4'(k), p);
      rd(4'h0);
      for (int i = 0; i < 3; i++) rd(4'(p + 20'(i)) ^ 4'h5);
    end
    cmd(CMD_DATA_READ);
    rd(4'h0);
    rd(4'h4 ^ 4'h5);
    load(CMD_DATA_LOAD, 20'h00040);
    rd(4'h0);
    rd(4'h0);
  endtask

  task automatic t_poll;
    svcReq = 1'b1;
    cmd(CMD_POLL);
    rd(4'h1 << POLL_LINE);
    rd(4'h0);
    svcReq = 1'b0;
    cmd(CMD_POLL);
    rd(4'h0);
  endtask

  task automatic t_ops;
    load(CMD_DATA_LOAD, 20'h00040);
    cmd(CMD_DEV_OP);
    settle;
    check(24'(seenOp), 24'h0);
    load(CMD_DATA_LOAD, BASE);
    cmd(CMD_DEV_OP);
    settle;
    check(24'(seenOp), 24'h1);
    cmd(CMD_HALT);
    settle;
    check(24'(seenHalt), 24'h1);
    load(CMD_DATA_LOAD, 20'h00040);
    cmd(CMD_UNCONFIGURE);
    settle;
    check(24'(configured), 24'h1);
    load(CMD_DATA_LOAD, BASE + 20'h7ff);
    cmd(CMD_UNCONFIGURE);
    settle;
    check(24'(configured), 24'h0);
    check(24'(chain_out), 24'h0);
    load(CMD_CONFIGURE, BASE);
    cmd(CMD_RESET);
    settle;
    check(24'(configured), 24'h0);
    check(24'(seenRst), 24'h1);
  endtask

  // reset, then the scenarios in turn
  initial begin
    reset_n = 1'b0;
    chain_in = 1'b1;
    svcReq = 1'b0;
    wrReady = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_idle;
    t_ident;
    t_config;
    t_fill_drain;
    t_read;
    t_poll;
    t_ops;
    final_report;
  end

  // watchdog, well past the expected run of about 56 us
  initial begin
    #400000;
    mismatches++;
    final_report;
  end
endmodule
